// ===== dv/tb_branch_increment_exec.sv
`timescale 1ns/10ps
`default_nettype none
`include "branch_increment_exec_defines.svh"

// Compare got against expected; four-state so X matches only X
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("CHECK FAILED %0t: got %h exp %h", $time, \
  got, exp); end end

module tb_branch_increment_exec;
  import bie_pkg::*;
  logic clock; // 200 MHz core clock
  logic srst; // Synchronous reset, active high
  logic instr_valid; // One word per cycle while high
  logic [11:0] instr; // Instruction word
  logic [7:0] file_data; // Addressed file register value
  logic [7:0] status_in; // Status byte, page bits at 6:5
  logic [10:0] pc; // Fetch address
  writeback_t wb; // Write-back bundle
  logic discarding; // Dropped-word pulse
  logic undecoded; // Foreign opcode pulse
  int n_mismatch; // Mismatches seen
  int samples_checked; // Comparisons made

  branch_increment_exec #(.PC_WIDTH(11), .DATA_WIDTH(8)) uut (
    .CLOCK(clock), .SRST(srst), .INSTR_VALID(instr_valid),
    .INSTR(instr), .FILE_DATA(file_data), .STATUS_IN(status_in),
    .PC(pc), .WB(wb), .DISCARDING(discarding), .UNDECODED(undecoded));

  // Free-running clock, 5 ns period
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Build an increment-family word from opcode, destination and address
  function automatic logic [11:0] fw(input logic [5:0] op,
                                     input logic d, input logic [4:0] a);
    return {op, d, a};
  endfunction

  // Present one word at a rising edge; outputs seen after it belong to
  // the word presented one step earlier
  task automatic step(input logic v, input logic [11:0] w,
                      input logic [7:0] fd);
    @(posedge clock);
    instr_valid <= v;
    instr <= w;
    file_data <= fd;
    #1;
  endtask

  // Jump: target from immediate and page bits, next word dropped
  task automatic t_jump;
    step(1'b1, 12'hba5, 8'h00);
    step(1'b1, fw(6'h0a, 1'b1, 5'h03), 8'h10);
    `CHK(pc, 11'h5a5)
    `CHK({wb.w_we, wb.f_we, wb.z_we}, 3'h0)
    step(1'b0, 12'h000, 8'h00);
    `CHK(discarding, 1'b1)
    `CHK(pc, 11'h5a6)
    `CHK({wb.w_we, wb.f_we, wb.z_we}, 3'h0)
    $display("test jump done");
  endtask

  // Plain increment: wrap to zero into file, then non-zero into W
  task automatic t_increment_file;
    step(1'b1, fw(6'h0a, 1'b1, 5'h1f), 8'hff);
    step(1'b1, fw(6'h0a, 1'b0, 5'h02), 8'h12);
    `CHK({wb.w_we, wb.f_we, wb.f_addr}, 7'h3f)
    `CHK({wb.data, wb.z_we, wb.z_val}, 10'h003)
    step(1'b0, 12'h000, 8'h00);
    `CHK({wb.w_we, wb.f_we, wb.f_addr}, 7'h42)
    `CHK({wb.data, wb.z_we, wb.z_val}, 10'h04e)
    `CHK(discarding, 1'b0)
    $display("test increment done");
  endtask

  // Skip increment: zero result drops next word even across a gap
  task automatic t_skip;
    step(1'b1, fw(6'h0f, 1'b0, 5'h04), 8'hff);
    step(1'b0, 12'h000, 8'h00);
    `CHK({wb.w_we, wb.f_we, wb.data}, 10'h200)
    `CHK(wb.z_we, 1'b0)
    step(1'b1, fw(6'h0a, 1'b1, 5'h05), 8'h20);
    step(1'b0, 12'h000, 8'h00);
    `CHK(discarding, 1'b1)
    `CHK({wb.w_we, wb.f_we, wb.z_we}, 3'h0)
    step(1'b1, fw(6'h0f, 1'b1, 5'h06), 8'h41);
    step(1'b1, fw(6'h0a, 1'b0, 5'h07), 8'h7f);
    `CHK({wb.f_we, wb.data, wb.z_we}, 10'h284)
    step(1'b0, 12'h000, 8'h00);
    `CHK(discarding, 1'b0)
    `CHK({wb.w_we, wb.data}, 9'h180)
    $display("test skip done");
  endtask

  // Top bits 100 are not a jump: flagged, nothing written
  task automatic t_other;
    step(1'b1, 12'h9ff, 8'h00);
    step(1'b0, 12'h000, 8'h00);
    `CHK(undecoded, 1'b1)
    `CHK({wb.w_we, wb.f_we, wb.z_we}, 3'h0)
    $display("test other done");
  endtask

  // Reset in mid-run clears a pending drop; the next word executes
  task automatic t_reset;
    step(1'b1, fw(6'h0f, 1'b0, 5'h08), 8'hff);
    step(1'b0, 12'h000, 8'h00);
    @(posedge clock);
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    #1;
    `CHK(pc, 11'h000)
    `CHK({wb, discarding, undecoded}, 18'h00000)
    step(1'b1, fw(6'h0a, 1'b1, 5'h09), 8'h05);
    step(1'b0, 12'h000, 8'h00);
    `CHK({discarding, wb.f_we, wb.data}, 10'h106)
    `CHK(pc, 11'h001)
    $display("test reset done");
  endtask

  // Print counts and verdict, then end the run
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch,
             samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    srst = 1'b1;
    instr_valid = 1'b0;
    instr = 12'h000;
    file_data = 8'h00;
    status_in = 8'hc5; // Page bits 2'b10, others set as decoys
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    #1;
    `CHK(pc, 11'h000)
    `CHK({wb, discarding, undecoded}, 18'h00000)
    t_jump();
    t_increment_file();
    t_skip();
    t_other();
    t_reset();
    stop_test();
  end
endmodule

`default_nettype wire

// ===== hw/bie_pkg.sv
`default_nettype none

package bie_pkg;

  // Execution state: discard follows execute after a jump or a zero-result skip
  typedef enum logic [1:0] {
    ST_EXECUTE = 2'h0,
    ST_DISCARD = 2'h1
  } state_t;

  // Result write-back bundle toward W, file and zero flag
  typedef struct packed {
    logic w_we;
    logic f_we;
    logic [4:0] f_addr;
    logic [7:0] data;
    logic z_we;
    logic z_val;
  } writeback_t;

endpackage

`default_nettype wire

// ===== hw/branch_increment_exec.sv
`timescale 1ns/10ps
`default_nettype none
`include "branch_increment_exec_defines.svh"

module branch_increment_exec #(
  parameter int PC_WIDTH = 11,
  parameter int DATA_WIDTH = 8
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic INSTR_VALID,
  input wire logic [`BIE_IW-1:0] INSTR,
  input wire logic [DATA_WIDTH-1:0] FILE_DATA,
  input wire logic [DATA_WIDTH-1:0] STATUS_IN,
  output logic [PC_WIDTH-1:0] PC,
  output bie_pkg::writeback_t WB,
  output logic DISCARDING,
  output logic UNDECODED
);
  import bie_pkg::*;

  // Execution state, decides whether the current word is dropped
  state_t state;
  state_t next_state;
  // Incremented operand and its zero detect
  logic [DATA_WIDTH-1:0] inc_sum;
  logic inc_zero;
  // Decoded instruction classes
  logic dec_jump;
  logic dec_inc;
  logic dec_skip;
  // A word is executed only when valid and not being dropped
  logic take;

  // Six-bit opcode compare used by both increment decode lines
  function automatic logic op6_is(input logic [`BIE_IW-1:0] iw,
                                  input logic [5:0] op);
    op6_is = (iw[`BIE_OP6_HI:`BIE_OP6_LO] == op);
  endfunction

  // Shared incrementer; both increment forms use the same datapath
  increment_unit #(
    .WIDTH(DATA_WIDTH)
  ) u_inc (
    .operand(FILE_DATA),
    .sum(inc_sum),
    .zero(inc_zero)
  );

  // Decode of the three handled instructions
  always_comb begin
    take = INSTR_VALID && (state == ST_EXECUTE);
    dec_jump = (INSTR[`BIE_OP3_HI:`BIE_OP3_LO] == `BIE_OP_JUMP);
    dec_inc = op6_is(INSTR, `BIE_OP_INC);
    dec_skip = op6_is(INSTR, `BIE_OP_INCSKIP);
  end

  // Next state: jump and zero skip both drop the fetched word
  always_comb begin
    next_state = state;
    case (state)
      ST_EXECUTE: begin
        if (take && dec_jump) begin
          next_state = ST_DISCARD;
        end else if (take && dec_skip && inc_zero) begin
          next_state = ST_DISCARD;
        end
      end
      ST_DISCARD: begin
        // Leave only once the dropped word has actually gone by
        if (INSTR_VALID) begin
          next_state = ST_EXECUTE;
        end
      end
      default: begin
        next_state = ST_EXECUTE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state <= ST_EXECUTE;
    end else begin
      state <= next_state;
    end
  end

  // Program counter: reload on jump, else step once per word
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      PC <= PC_WIDTH'(`BIE_PC_RESET);
    end else if (take && dec_jump) begin
      // Page bits select the upper part of the target
      PC <= PC_WIDTH'({STATUS_IN[`BIE_PAGE_HI],
                       STATUS_IN[`BIE_PAGE_LO],
                       INSTR[`BIE_K_HI:`BIE_K_LO]});
    end else if (INSTR_VALID) begin
      // Dropped words still advance the fetch address
      PC <= PC + PC_WIDTH'(1);
    end
  end

  // Write-back: one-cycle strobes with data and destination
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      WB <= '0;
    end else begin
      WB.w_we <= 1'b0;
      WB.f_we <= 1'b0;
      WB.z_we <= 1'b0;
      if (take && (dec_inc || dec_skip)) begin
        // Destination 0 goes to W, 1 goes back to the file
        WB.w_we <= (INSTR[`BIE_DEST_BIT] == `BIE_DEST_W);
        WB.f_we <= (INSTR[`BIE_DEST_BIT] == `BIE_DEST_F);
        WB.f_addr <= INSTR[`BIE_FADDR_HI:`BIE_FADDR_LO];
        WB.data <= inc_sum;
        // Only the plain form touches the zero flag
        WB.z_we <= dec_inc;
        WB.z_val <= inc_zero;
      end
    end
  end

  // Marks a cycle spent as a no-operation
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      DISCARDING <= 1'b0;
    end else begin
      DISCARDING <= INSTR_VALID && (state == ST_DISCARD);
    end
  end

  // Flags a word this block does not execute, for the core to handle
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      UNDECODED <= 1'b0;
    end else begin
      UNDECODED <= take && !(dec_jump || dec_inc || dec_skip);
    end
  end

  // Checks sleep through reset; each one follows a single rule
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SRST);

  chk_jump_no_flags: assert property (
    take && dec_jump |=> !WB.z_we && !WB.w_we && !WB.f_we)
    else $error("jump wrote a result or flag");

  chk_jump_low_target: assert property (
    take && dec_jump |=> PC[`BIE_K_HI:`BIE_K_LO]
      == $past(INSTR[`BIE_K_HI:`BIE_K_LO]))
    else $error("jump target low bits wrong");

  chk_jump_page_bits: assert property (
    take && dec_jump |=> PC[`BIE_PC_PAGE_HI:`BIE_PC_PAGE_LO]
      == {$past(STATUS_IN[`BIE_PAGE_HI]), $past(STATUS_IN[`BIE_PAGE_LO])})
    else $error("jump page bits wrong");

  chk_jump_two_cycles: assert property (
    take && dec_jump ##1 INSTR_VALID |=> DISCARDING && !WB.w_we
      && !WB.f_we && state == ST_EXECUTE)
    else $error("jump did not drop the next word");

  chk_dest_select: assert property (
    take && (dec_inc || dec_skip) |=>
      WB.f_we == $past(INSTR[`BIE_DEST_BIT]) && WB.w_we != WB.f_we)
    else $error("destination select wrong");

  chk_inc_zero_flag: assert property (
    take && dec_inc |=> WB.z_we && WB.z_val == (WB.data == '0)
      && WB.data == $past(FILE_DATA) + 1'b1
      && state == ST_EXECUTE)
    else $error("increment zero flag or timing wrong");

  chk_skip_keeps_flags: assert property (
    take && dec_skip |=> !WB.z_we)
    else $error("skip increment touched status");

  chk_skip_on_zero: assert property (
    take && dec_skip |=> (state == ST_DISCARD) == ($past(FILE_DATA) == '1))
    else $error("skip decision wrong");

  chk_discard_nop: assert property (
    state == ST_DISCARD && INSTR_VALID |=> DISCARDING && !WB.z_we
      && !WB.w_we && !WB.f_we && !UNDECODED)
    else $error("dropped word was executed");

  chk_inc_wrap: assert property (
    take && dec_inc && FILE_DATA == '1 |=> WB.data == '0 && WB.z_val)
    else $error("increment did not wrap to zero");

  chk_skip_adds_one: assert property (
    take && dec_skip |=> WB.data == $past(FILE_DATA) + 1'b1)
    else $error("skip increment result wrong");

  chk_gap_keeps_drop: assert property (
    state == ST_DISCARD && !INSTR_VALID |=> state == ST_DISCARD
      && !DISCARDING)
    else $error("gap released the pending drop");

  chk_pc_step: assert property (
    INSTR_VALID && !(take && dec_jump) |=> PC == $past(PC) + 1'b1)
    else $error("fetch address did not step");

  chk_decoded_not_flagged: assert property (
    take && (dec_jump || dec_inc || dec_skip) |=> !UNDECODED)
    else $error("handled word flagged as foreign");

endmodule

`default_nettype wire

// ===== hw/branch_increment_exec_defines.svh
`ifndef BRANCH_INCREMENT_EXEC_DEFINES_SVH
`define BRANCH_INCREMENT_EXEC_DEFINES_SVH

// Instruction word layout
`define BIE_IW 12
`define BIE_OP3_HI 11
`define BIE_OP3_LO 9
`define BIE_OP6_HI 11
`define BIE_OP6_LO 6
`define BIE_DEST_BIT 5
`define BIE_FADDR_HI 4
`define BIE_FADDR_LO 0
`define BIE_K_HI 8
`define BIE_K_LO 0

// Opcode patterns
`define BIE_OP_JUMP 3'h5
`define BIE_OP_INC 6'h0a
`define BIE_OP_INCSKIP 6'h0f

// Page select bits in the status byte
`define BIE_PAGE_HI 6
`define BIE_PAGE_LO 5

// Page bits of the program counter loaded by a jump
`define BIE_PC_PAGE_HI 10
`define BIE_PC_PAGE_LO 9

// Destination select values
`define BIE_DEST_W 1'h0
`define BIE_DEST_F 1'h1

// Reset values
`define BIE_PC_RESET 11'h000
`define BIE_DATA_ZERO 8'h00

`endif

// ===== hw/increment_unit.sv
`timescale 1ns/10ps
`default_nettype none

// Wrapping increment with a zero detect on the result
module increment_unit #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] operand,
  output logic [WIDTH-1:0] sum,
  output logic zero
);

  // All ones wraps to zero since the carry is dropped
  always_comb begin
    sum = operand + {{(WIDTH-1){1'b0}}, 1'b1};
    zero = (sum == '0);
  end

endmodule

`default_nettype wire
